// ---- pkg/nbcd_regs.vh ----
`ifndef NBCD_REGS_VH
`define NBCD_REGS_VH
// =====================================
// operation codes from the user port
`define NBCD_OP_CMD 3'h0
`define NBCD_OP_ADDR 3'h1
`define NBCD_OP_WDATA 3'h2
`define NBCD_OP_RDATA 3'h3
`define NBCD_OP_WAITRDY 3'h4
// =====================================
// command codes
`define NBCD_CMD_RESET 8'hff
`define NBCD_CMD_STATUS 8'h70
`define NBCD_CMD_PROG 8'h10
`define NBCD_CMD_ERASE 8'hd0
`define NBCD_CMD_CACHE_PROG 8'h15
// =====================================
// strobe timing in ns and cycles at 10 ns
`define NBCD_CLK_NS 10
`define NBCD_WP_NS 12
`define NBCD_WH_NS 10
`define NBCD_RP_NS 12
`define NBCD_REH_NS 10
`define NBCD_WHR_NS 60
`define NBCD_WB_NS 100
`define NBCD_RHOH_NS 25
`define NBCD_WP_CYC ((`NBCD_WP_NS + `NBCD_CLK_NS - 1) / `NBCD_CLK_NS)
`define NBCD_WH_CYC ((`NBCD_WH_NS + `NBCD_CLK_NS - 1) / `NBCD_CLK_NS)
`define NBCD_RP_CYC ((`NBCD_RP_NS + `NBCD_CLK_NS - 1) / `NBCD_CLK_NS)
`define NBCD_REH_CYC ((`NBCD_REH_NS + `NBCD_CLK_NS - 1) / `NBCD_CLK_NS)
`define NBCD_WHR_CYC ((`NBCD_WHR_NS + `NBCD_CLK_NS - 1) / `NBCD_CLK_NS)
`define NBCD_WB_CYC ((`NBCD_WB_NS + `NBCD_CLK_NS - 1) / `NBCD_CLK_NS)
// =====================================
// busy limits in ns; largest bounds the ready wait
`define NBCD_ARRAY_FETCH_NS 25000
`define NBCD_READ_CACHE_BUSY_NS 25000
`define NBCD_PAGE_COPY_BUSY_NS 30000
`define NBCD_WRITE_CACHE_BUSY_NS 700000
`define NBCD_PROG_NS 700000
`define NBCD_BLOCK_CLEAR_NS 5000000
`define NBCD_RESET_ERASE_NS 500000
`define NBCD_BLOCK_CLEAR_CYC (`NBCD_BLOCK_CLEAR_NS / `NBCD_CLK_NS)
`define NBCD_MAX_PARTIAL 3'h4
`define NBCD_FIFO_DEPTH 16
`endif

// ---- core/nbcd_fifo.v ----
`timescale 1ns/10ps
`default_nettype none
module nbcd_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire i_ref_clk,
   input wire i_reset_n,
   // fill side
   input wire i_in_valid,
   input wire [WIDTH-1:0] i_in_data,
   output reg o_in_ready,
   // drain side
   output reg o_out_valid,
   output reg [WIDTH-1:0] o_out_data,
   input wire i_out_ready
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire push;
   wire pop;
   wire [AW:0] cnt_next;
   wire valid_next;
   assign push = i_in_valid && o_in_ready;
   // output register counts toward the depth
   assign valid_next = pop || (o_out_valid && !i_out_ready);
   assign pop = (cnt_reg != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);
   assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   always @(posedge i_ref_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= i_in_data;
      end
   end
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         o_in_ready <= 1'b0;
         o_out_valid <= 1'b0;
         o_out_data <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
            o_out_data <= mem_reg[rd_reg];
            o_out_valid <= 1'b1;
         end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
         end
         cnt_reg <= cnt_next;
         o_in_ready <= ((cnt_next + {{AW{1'b0}}, valid_next}) < DEPTH);
      end
   end
endmodule
`default_nettype wire

// ---- core/nbcd_host.v ----
`timescale 1ns/10ps
`default_nettype none
`include "nbcd_regs.vh"
module nbcd_host #(
   parameter BUSY_LIMIT_CYC = `NBCD_BLOCK_CLEAR_CYC
) (
   // clock and reset
   input wire i_ref_clk,
   input wire i_reset_n,
   // request port
   input wire i_req_valid,
   input wire [2:0] i_req_op,
   input wire [7:0] i_req_byte,
   output reg o_req_ready,
   // write data stream
   input wire i_wdata_valid,
   input wire [7:0] i_wdata,
   output wire o_wdata_ready,
   // read data stream
   output reg o_rdata_valid,
   output reg [7:0] o_rdata,
   // status
   input wire i_write_enable,
   output reg o_busy_timeout,
   output reg o_partial_limit,
   // flash pins
   output reg o_cmd_latch,
   output reg o_addr_latch,
   output reg o_chip_sel_n,
   output reg o_write_strobe_n,
   output reg o_read_strobe_n,
   output reg o_write_protect_n,
   output reg [7:0] o_io_out,
   output reg o_io_oe,
   input wire [7:0] i_io_in,
   input wire i_ready_busy_n
);
   // =====================================
   // states
   localparam ST_IDLE = 6'h01;
   localparam ST_WLOW = 6'h02;
   localparam ST_WHIGH = 6'h04;
   localparam ST_RLOW = 6'h08;
   localparam ST_RHIGH = 6'h10;
   localparam ST_WAIT = 6'h20;
   reg [5:0] state_reg;
   reg [31:0] cnt_reg;
   reg [2:0] op_reg;
   reg [7:0] cmd_reg;
   reg [2:0] partial_reg;
   reg [7:0] io_s1_reg;
   reg [7:0] io_s2_reg;
   reg rb_s1_reg;
   reg rb_s2_reg;
   reg read_busy_reg;
   wire fifo_valid;
   wire [7:0] fifo_data;
   wire fifo_take;
   // =====================================
   // write data buffer
   assign fifo_take = (state_reg == ST_IDLE) && i_req_valid && o_req_ready && (i_req_op == `NBCD_OP_WDATA);
   nbcd_fifo #(
      .WIDTH(8),
      .DEPTH(`NBCD_FIFO_DEPTH),
      .AW(4)
   ) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_in_valid(i_wdata_valid),
      .i_in_data(i_wdata),
      .o_in_ready(o_wdata_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(fifo_data),
      .i_out_ready(fifo_take)
   );
   // =====================================
   // pin synchronisers
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         io_s1_reg <= 8'h00;
         io_s2_reg <= 8'h00;
         rb_s1_reg <= 1'b0;
         rb_s2_reg <= 1'b0;
      end else begin
         io_s1_reg <= i_io_in;
         io_s2_reg <= io_s1_reg;
         rb_s1_reg <= i_ready_busy_n;
         rb_s2_reg <= rb_s1_reg;
      end
   end
   // =====================================
   // cycle sequencer
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 32'h0;
         op_reg <= 3'h0;
         cmd_reg <= 8'h00;
         partial_reg <= 3'h0;
         read_busy_reg <= 1'b0;
         o_req_ready <= 1'b0;
         o_rdata_valid <= 1'b0;
         o_rdata <= 8'h00;
         o_busy_timeout <= 1'b0;
         o_partial_limit <= 1'b0;
         o_cmd_latch <= 1'b0;
         o_addr_latch <= 1'b0;
         o_chip_sel_n <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
         o_write_protect_n <= 1'b0;
         o_io_out <= 8'h00;
         o_io_oe <= 1'b0;
      end else begin
         o_rdata_valid <= 1'b0;
         o_write_protect_n <= i_write_enable;
         case (state_reg)
            ST_IDLE: begin
               o_cmd_latch <= 1'b0;
               o_addr_latch <= 1'b0;
               o_write_strobe_n <= 1'b1;
               o_read_strobe_n <= 1'b1;
               o_io_oe <= 1'b0;
               o_chip_sel_n <= !i_req_valid;
               o_req_ready <= 1'b1;
               if (i_req_valid && o_req_ready &&
                   (i_req_op != `NBCD_OP_WDATA || fifo_valid)) begin
                  o_req_ready <= 1'b0;
                  op_reg <= i_req_op;
                  cnt_reg <= 32'h0;
                  o_chip_sel_n <= 1'b0;
                  case (i_req_op)
                     `NBCD_OP_CMD: begin
                        // while read busy only reset or status may go out
                        if (read_busy_reg && i_req_byte != `NBCD_CMD_RESET &&
                            i_req_byte != `NBCD_CMD_STATUS) begin
                           state_reg <= ST_IDLE;
                        end else begin
                           cmd_reg <= i_req_byte;
                           o_cmd_latch <= 1'b1;
                           o_io_out <= i_req_byte;
                           o_io_oe <= 1'b1;
                           o_write_strobe_n <= 1'b0;
                           state_reg <= ST_WLOW;
                           if (i_req_byte == `NBCD_CMD_PROG || i_req_byte == `NBCD_CMD_CACHE_PROG) begin
                              if (partial_reg == `NBCD_MAX_PARTIAL - 3'h1) begin
                                 o_partial_limit <= 1'b1;
                              end
                              partial_reg <= partial_reg + 3'h1;
                           end else if (i_req_byte == `NBCD_CMD_ERASE) begin
                              partial_reg <= 3'h0;
                              o_partial_limit <= 1'b0;
                           end
                        end
                     end
                     `NBCD_OP_ADDR: begin
                        o_addr_latch <= 1'b1;
                        o_io_out <= i_req_byte;
                        o_io_oe <= 1'b1;
                        o_write_strobe_n <= 1'b0;
                        state_reg <= ST_WLOW;
                     end
                     `NBCD_OP_WDATA: begin
                        o_io_out <= fifo_data;
                        o_io_oe <= 1'b1;
                        o_write_strobe_n <= 1'b0;
                        state_reg <= ST_WLOW;
                     end
                     `NBCD_OP_RDATA: begin
                        o_read_strobe_n <= 1'b0;
                        state_reg <= ST_RLOW;
                     end
                     default: begin
                        o_busy_timeout <= 1'b0;
                        state_reg <= ST_WAIT;
                     end
                  endcase
               end
            end
            ST_WLOW: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= `NBCD_WP_CYC - 1) begin
                  o_write_strobe_n <= 1'b1;
                  cnt_reg <= 32'h0;
                  state_reg <= ST_WHIGH;
               end
            end
            ST_WHIGH: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= `NBCD_WH_CYC + `NBCD_WB_CYC - 1) begin
                  o_cmd_latch <= 1'b0;
                  o_addr_latch <= 1'b0;
                  o_io_oe <= 1'b0;
                  if (op_reg == `NBCD_OP_CMD && cmd_reg != `NBCD_CMD_STATUS &&
                      cmd_reg != `NBCD_CMD_RESET && !rb_s2_reg) begin
                     read_busy_reg <= 1'b1;
                  end
                  state_reg <= ST_IDLE;
               end
            end
            ST_RLOW: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= `NBCD_RP_CYC + 1) begin
                  // capture after two-stage sync of the bus
                  o_rdata <= io_s2_reg;
                  o_rdata_valid <= 1'b1;
                  o_read_strobe_n <= 1'b1;
                  cnt_reg <= 32'h0;
                  state_reg <= ST_RHIGH;
               end
            end
            ST_RHIGH: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= `NBCD_REH_CYC + 2) begin
                  // chip select release ends any extended output drive
                  o_chip_sel_n <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               cnt_reg <= cnt_reg + 32'h1;
               o_write_strobe_n <= 1'b1;
               o_read_strobe_n <= 1'b1;
               if (rb_s2_reg && cnt_reg >= `NBCD_WB_CYC) begin
                  read_busy_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end else if (cnt_reg >= BUSY_LIMIT_CYC) begin
                  // exceeds every busy limit
                  o_busy_timeout <= 1'b1;
                  read_busy_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- tb/nbcd_host_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module nbcd_host_sva (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // watched ports
   input wire logic i_write_enable,
   input wire logic o_rdata_valid,
   input wire logic o_cmd_latch,
   input wire logic o_addr_latch,
   input wire logic o_chip_sel_n,
   input wire logic o_write_strobe_n,
   input wire logic o_read_strobe_n,
   input wire logic o_write_protect_n,
   input wire logic o_io_oe
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // ==========================================
   // strobe shapes
   sequence s_we_low;
      !o_write_strobe_n [*2] ##1 o_write_strobe_n;
   endsequence
   sequence s_rd_low;
      !o_read_strobe_n [*4] ##1 o_read_strobe_n;
   endsequence
   property p_latch_excl;
      !(o_cmd_latch && o_addr_latch);
   endproperty
   property p_we_pulse;
      $fell(o_write_strobe_n) |-> s_we_low;
   endproperty
   property p_cle_start;
      $rose(o_cmd_latch) |-> $fell(o_write_strobe_n);
   endproperty
   property p_we_ctx;
      !o_write_strobe_n |-> !o_chip_sel_n && o_read_strobe_n && o_io_oe;
   endproperty
   property p_rd_ctx;
      !o_read_strobe_n |-> !o_chip_sel_n && o_write_strobe_n && !o_cmd_latch && !o_addr_latch && !o_io_oe;
   endproperty
   property p_rd_pulse;
      $fell(o_read_strobe_n) |-> s_rd_low;
   endproperty
   property p_rdata;
      $rose(o_read_strobe_n) |-> ##[0:1] o_rdata_valid;
   endproperty
   property p_wp;
      $past(i_reset_n) |-> o_write_protect_n == $past(i_write_enable);
   endproperty
   property p_standby;
      o_chip_sel_n |-> o_write_strobe_n && o_read_strobe_n;
   endproperty
   a_latch_excl: assert property (p_latch_excl)
      else $error("both latch enables high");
   a_we_pulse: assert property (p_we_pulse)
      else $error("write strobe pulse misshaped");
   a_cle_start: assert property (p_cle_start)
      else $error("command latch without write strobe");
   a_we_ctx: assert property (p_we_ctx)
      else $error("write strobe in wrong context");
   a_rd_ctx: assert property (p_rd_ctx)
      else $error("read strobe in wrong context");
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe pulse misshaped");
   a_rdata: assert property (p_rdata)
      else $error("read byte not delivered");
   a_wp: assert property (p_wp)
      else $error("write protect not following enable");
   a_standby: assert property (p_standby)
      else $error("strobe while deselected");
endmodule
bind nbcd_host nbcd_host_sva chk (.*);
`default_nettype wire

// ---- tb/nbcd_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module nbcd_flash_model (
   // clock
   input wire logic i_ref_clk,
   // host pins
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_cs_n,
   input wire logic i_we_n,
   input wire logic i_read_strobe_n,
   input wire logic i_wp_n,
   input wire logic [7:0] i_io,
   // device pins
   output logic [7:0] o_io_drv,
   output logic o_ready_busy_n
);
   logic [7:0] last_cmd = 8'hee, last_addr = 8'h00, last_data = 8'h00, col = 8'h00, drv = 8'h00;
   logic status_mode = 1'b0, reading = 1'b0;
   int n_cmd = 0, n_data = 0, n_busy = 0, busy_cnt = 0, busy_len = 50;
   // ==========================================
   // input cycles on write strobe rise
   always @(posedge i_we_n) begin
      if (!i_cs_n && i_read_strobe_n) begin
         if (i_cle && !i_ale) begin
            last_cmd = i_io;
            n_cmd++;
            status_mode = (i_io == 8'h70);
            if (i_io == 8'hff) begin
               busy_cnt = 10;
            end else if (i_io == 8'h30 || i_io == 8'h31 || i_io == 8'h3f || i_io == 8'h3a) begin
               busy_cnt = busy_len;
               n_busy++;
            end else if ((i_io == 8'h10 || i_io == 8'h15 || i_io == 8'hd0) && i_wp_n) begin
               busy_cnt = busy_len;
               n_busy++;
            end
         end else if (i_ale && !i_cle) begin
            last_addr = i_io;
            col = 8'h00;
         end else if (!i_ale && !i_cle && i_wp_n) begin
            last_data = i_io;
            n_data++;
         end
      end
   end
   always @(posedge i_ref_clk) if (busy_cnt > 0) busy_cnt--;
   assign o_ready_busy_n = (busy_cnt == 0);
   // ==========================================
   // serial output, held 25 ns after rise
   always @(negedge i_read_strobe_n) begin
      if (!i_cs_n) begin
         reading = 1'b1;
         // old byte held briefly after the fall
         #5;
         drv = status_mode ? {1'b1, o_ready_busy_n, 6'h00} : col + 8'h5a;
         if (!status_mode) col++;
      end
   end
   // short high time keeps driving, long one releases
   always @(posedge i_read_strobe_n) begin
      #25;
      if (i_read_strobe_n) reading = 1'b0;
   end
   always @(posedge i_cs_n or posedge i_cle or posedge i_ale or negedge i_we_n) reading = 1'b0;
   assign o_io_drv = reading ? drv : ~drv;
endmodule
`default_nettype wire

// ---- tb/nand_bus_cycle_decode_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "nbcd_regs.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("unexpected at %0t: %h, wanted %h", $time, (a), (e)); end end
module nand_bus_cycle_decode_bench;
   typedef struct packed {logic [2:0] op; logic [7:0] b; logic [7:0] e;} nbcd_row_t;
   logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_req_valid = 1'b0, i_wdata_valid = 1'b0, i_write_enable = 1'b1;
   logic [2:0] i_req_op = 3'h0;
   logic [7:0] i_req_byte = 8'h00, i_wdata = 8'h00, o_rdata, o_io_out, i_io_in, dev_io, got = 8'h00, act;
   logic o_req_ready, o_wdata_ready, o_rdata_valid, o_busy_timeout, o_partial_limit, o_cmd_latch, o_addr_latch;
   logic o_chip_sel_n, o_write_strobe_n, o_read_strobe_n, o_write_protect_n, o_io_oe, i_ready_busy_n;
   int n_errors = 0, n_compared = 0, k, nb, nd;
   nbcd_row_t rows [10] = '{'{3'h0, 8'h00, 8'h00}, '{3'h1, 8'h12, 8'h12}, '{3'h1, 8'h34, 8'h34},
      '{3'h0, 8'h30, 8'h30}, '{3'h4, 8'h00, 8'h00}, '{3'h3, 8'h00, 8'h5a}, '{3'h3, 8'h00, 8'h5b},
      '{3'h3, 8'h00, 8'h5c}, '{3'h0, 8'h80, 8'h80}, '{3'h1, 8'h00, 8'h00}};
   always #5 i_ref_clk = ~i_ref_clk;
   assign i_io_in = o_io_oe ? o_io_out : dev_io;
   always @(posedge i_ref_clk) if (o_rdata_valid === 1'b1) got <= o_rdata;
   nbcd_host #(.BUSY_LIMIT_CYC(300)) uut (.*);
   nbcd_flash_model dev (.i_ref_clk(i_ref_clk), .i_cle(o_cmd_latch), .i_ale(o_addr_latch),
      .i_cs_n(o_chip_sel_n), .i_we_n(o_write_strobe_n), .i_read_strobe_n(o_read_strobe_n),
      .i_wp_n(o_write_protect_n), .i_io(o_io_out), .o_io_drv(dev_io), .o_ready_busy_n(i_ready_busy_n));
   // ==========================================
   // one request, then wait for idle again
   task automatic req(input logic [2:0] op, input logic [7:0] b);
      int w;
      @(negedge i_ref_clk);
      i_req_valid = 1'b1;
      i_req_op = op;
      i_req_byte = b;
      w = 0;
      while (o_req_ready !== 1'b1 && w < 2000) begin @(negedge i_ref_clk); w++; end
      @(negedge i_ref_clk);
      i_req_valid = 1'b0;
      w = 0;
      while (o_req_ready !== 1'b1 && w < 2000) begin @(negedge i_ref_clk); w++; end
   endtask
   task automatic results;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      results();
   end
   initial begin
      repeat (3) @(negedge i_ref_clk);
      `CHK({o_chip_sel_n, o_io_oe, o_write_protect_n, o_req_ready}, 4'b1000);
      repeat (3) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      foreach (rows[i]) begin
         req(rows[i].op, rows[i].b);
         act = rows[i].op == `NBCD_OP_CMD ? dev.last_cmd : rows[i].op == `NBCD_OP_ADDR ? dev.last_addr :
            rows[i].op == `NBCD_OP_RDATA ? got : {7'h00, o_busy_timeout};
         `CHK(act, rows[i].e);
      end
      // read busy: only status and reset get through
      dev.busy_len = 200;
      req(`NBCD_OP_CMD, 8'h30);
      nb = dev.n_cmd;
      req(`NBCD_OP_CMD, 8'h00);
      `CHK(dev.n_cmd, nb);
      req(`NBCD_OP_CMD, 8'h70);
      req(`NBCD_OP_RDATA, 8'h00);
      `CHK(got, 8'h80);
      req(`NBCD_OP_CMD, 8'hff);
      `CHK(dev.n_cmd, nb + 2);
      req(`NBCD_OP_WAITRDY, 8'h00);
      // busy longer than the limit, then cleared
      dev.busy_len = 500;
      req(`NBCD_OP_CMD, 8'h30);
      req(`NBCD_OP_WAITRDY, 8'h00);
      `CHK(o_busy_timeout, 1'b1);
      req(`NBCD_OP_WAITRDY, 8'h00);
      `CHK(o_busy_timeout, 1'b0);
      // fill buffer until refused, drain to device
      dev.busy_len = 50;
      k = 0;
      repeat (24) begin
         @(negedge i_ref_clk);
         i_wdata_valid = (o_wdata_ready === 1'b1);
         i_wdata = k[7:0];
         if (o_wdata_ready === 1'b1) k++;
      end
      @(negedge i_ref_clk);
      i_wdata_valid = 1'b0;
      `CHK(k, 16);
      nd = dev.n_data;
      repeat (16) req(`NBCD_OP_WDATA, 8'h00);
      `CHK(dev.n_data - nd, 16);
      `CHK(dev.last_data, 8'h0f);
      `CHK(o_wdata_ready, 1'b1);
      // partial program count and erase
      nb = dev.n_busy;
      for (k = 0; k < 4; k++) begin
         req(`NBCD_OP_CMD, (k == 3) ? 8'h15 : 8'h10);
         req(`NBCD_OP_WAITRDY, 8'h00);
      end
      `CHK(o_partial_limit, 1'b1);
      `CHK(dev.n_busy - nb, 4);
      req(`NBCD_OP_CMD, 8'hd0);
      req(`NBCD_OP_WAITRDY, 8'h00);
      `CHK(o_partial_limit, 1'b0);
      // write protect blocks program and data
      i_write_enable = 1'b0;
      @(negedge i_ref_clk);
      i_wdata_valid = 1'b1;
      @(negedge i_ref_clk);
      i_wdata_valid = 1'b0;
      nb = dev.n_busy;
      nd = dev.n_data;
      req(`NBCD_OP_WDATA, 8'h00);
      req(`NBCD_OP_CMD, 8'h10);
      `CHK(dev.n_busy, nb);
      `CHK(dev.n_data, nd);
      `CHK(o_write_protect_n, 1'b0);
      results();
   end
endmodule
`default_nettype wire
